// *** include/fpcc_map.svh ***
// Register offsets, field positions, reset values and format widths for the compare unit.
`ifndef FPCC_MAP_SVH
`define FPCC_MAP_SVH

`define FPCC_OFF_SRC_A_LO 8'h00
`define FPCC_OFF_SRC_A_HI 8'h04
`define FPCC_OFF_SRC_B_LO 8'h08
`define FPCC_OFF_SRC_B_HI 8'h0c
`define FPCC_OFF_CMD      8'h10
`define FPCC_OFF_CTRL     8'h14
`define FPCC_OFF_CC       8'h18
`define FPCC_OFF_FLAGS    8'h1c
`define FPCC_OFF_LAST     8'h20
`define FPCC_OFF_COUNT    8'h24

`define FPCC_CMD_COND_LSB 0
`define FPCC_CMD_SEL_LSB  4
`define FPCC_CMD_FMT_LSB  8

`define FPCC_CTRL_INV_EN  0
`define FPCC_CTRL_COP_EN  1
`define FPCC_CTRL_PS_EN   2
`define FPCC_CTRL_RST     3'h6

`define FPCC_FLG_INV      0
`define FPCC_FLG_INV_EXC  1
`define FPCC_FLG_UNIMPL   2
`define FPCC_FLG_COPU     3
`define FPCC_FLG_RESV     4
`define FPCC_FLAGS_RST    5'h00
`define FPCC_CC_RST       8'h00

`define FPCC_SINGLE_EXP   8
`define FPCC_SINGLE_MAN   23
`define FPCC_DOUBLE_EXP   11
`define FPCC_DOUBLE_MAN   52

`endif

// *** include/fpcc_pkg.sv ***
// Types shared by the compare unit.
package fpcc_pkg;
  typedef enum logic [1:0] {
    FPCC_FMT_S,
    FPCC_FMT_D,
    FPCC_FMT_PS,
    FPCC_FMT_RSV
  } fpcc_fmt_t;

  typedef enum logic [0:0] {
    FPCC_BUS_IDLE,
    FPCC_BUS_RD_WAIT
  } fpcc_bus_t;
endpackage

// *** rtl/fpcc_rel.sv ***
// Ordering relations and NaN class of two operands in one binary format.
`timescale 1ns/1ps
module fpcc_rel #(
  parameter int EXP_W = 8,
  parameter int MAN_W = 23
) (
  input  wire logic [EXP_W+MAN_W:0] i_a,
  input  wire logic [EXP_W+MAN_W:0] i_b,
  output logic                      o_less,
  output logic                      o_equal,
  output logic                      o_unord,
  output logic                      o_signaling_nan,
  output logic                      o_quiet_nan
);
  localparam int W = EXP_W + MAN_W + 1;

  if (EXP_W < 2 || MAN_W < 2) begin : g_chk
    $error("fpcc_rel: exponent and mantissa need at least two bits.");
  end

  logic a_nan;
  logic b_nan;
  logic both_zero;
  logic mag_lt;
  logic mag_gt;
  logic ord_less;

  assign a_nan     = (&i_a[W-2:MAN_W]) & (|i_a[MAN_W-1:0]);
  assign b_nan     = (&i_b[W-2:MAN_W]) & (|i_b[MAN_W-1:0]);
  assign o_quiet_nan    = (a_nan & i_a[MAN_W-1]) | (b_nan & i_b[MAN_W-1]);
  assign o_signaling_nan    = (a_nan & ~i_a[MAN_W-1]) | (b_nan & ~i_b[MAN_W-1]);
  assign both_zero = ~(|i_a[W-2:0]) & ~(|i_b[W-2:0]);
  assign mag_lt    = i_a[W-2:0] < i_b[W-2:0];
  assign mag_gt    = i_a[W-2:0] > i_b[W-2:0];
  assign ord_less  = ~both_zero & ((i_a[W-1] & ~i_b[W-1]) | (~i_a[W-1] & ~i_b[W-1] & mag_lt) |
                                   (i_a[W-1] & i_b[W-1] & mag_gt));
  assign o_unord   = a_nan | b_nan;
  assign o_less    = ~o_unord & ord_less;
  assign o_equal   = ~o_unord & (both_zero | (i_a == i_b));
endmodule

// *** rtl/fpcc_pred.sv ***
// Predicate evaluation and invalid-operation detection for one compare lane.
`timescale 1ns/1ps
module fpcc_pred (
  input  wire logic       i_less,
  input  wire logic       i_equal,
  input  wire logic       i_unord,
  input  wire logic       i_signaling_nan,
  input  wire logic       i_quiet_nan,
  input  wire logic [3:0] i_cond,
  output logic            o_result,
  output logic            o_invalid
);
  // Each of the low three predicate bits enables one relation; code zero enables none.
  assign o_result  = (i_cond[2] & i_less) | (i_cond[1] & i_equal) | (i_cond[0] & i_unord);
  assign o_invalid = i_signaling_nan | (i_cond[3] & i_quiet_nan);
endmodule

// *** rtl/fpcc_top.sv ***
// Floating-point compare unit with condition codes, reached over an AHB-Lite slave port.
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "fpcc_map.svh"
module fpcc_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_hsel,
  input  wire logic [31:0]           i_haddr,
  input  wire logic [1:0]            i_htrans,
  input  wire logic                  i_hwrite,
  input  wire logic [2:0]            i_hsize,
  input  wire logic [31:0]           i_hwdata,
  input  wire logic                  i_hready,
  output logic                       o_hreadyout,
  output logic [31:0]                o_hrdata,
  output logic                       o_hresp,
  output logic [7:0]                 o_cond_codes,
  output logic                       o_inv_exc,
  output logic                       o_unimpl_exc,
  output logic                       o_copu_exc,
  output logic                       o_resv_exc,
  output fpcc_pkg::fpcc_fmt_t        o_last_fmt
);
  import fpcc_pkg::*;

  if (ADDR_W < 6 || ADDR_W > 32) begin : g_chk
    $error("fpcc_top: ADDR_W must lie between 6 and 32.");
  end

  // Bus slave state.
  fpcc_bus_t          bus_reg;
  logic               hreadyout_reg;
  logic [31:0]        hrdata_reg;
  logic               wr_pend_reg;
  logic [ADDR_W-1:0]  wr_addr_reg;
  logic [ADDR_W-1:0]  rd_addr_reg;
  logic               addr_take;

  // Software-visible state.
  logic [31:0]        src_a_lo_reg;
  logic [31:0]        src_a_hi_reg;
  logic [31:0]        src_b_lo_reg;
  logic [31:0]        src_b_hi_reg;
  logic [2:0]         ctrl_reg;
  logic [7:0]         cc_reg;
  logic [4:0]         flags_reg;
  logic [4:0]         flags_next;
  logic [9:0]         last_reg;
  logic [15:0]        count_reg;
  fpcc_fmt_t          fmt_reg;
  logic               inv_exc_reg;
  logic               unimpl_exc_reg;
  logic               copu_exc_reg;
  logic               resv_exc_reg;

  // Compare command decode.
  logic               go;
  logic [3:0]         cmd_cond;
  logic [2:0]         cmd_sel;
  logic [2:0]         cmd_sel_hi;
  fpcc_fmt_t          cmd_fmt;
  logic               is_ps;
  logic               copu_raise;
  logic               resv_raise;
  logic               unimpl_raise;
  logic               exec_ok;
  logic               inv_raise;
  logic               inv_take;
  logic               cc_write;

  // Lane relations.
  logic d_less, d_equal, d_unord, d_signaling_nan, d_quiet_nan;
  logic s_less, s_equal, s_unord, s_signaling_nan, s_quiet_nan;
  logic h_less, h_equal, h_unord, h_signaling_nan, h_quiet_nan;
  logic lo_less, lo_equal, lo_unord, lo_signaling_nan, lo_quiet_nan;
  logic lo_result, lo_inv;
  logic hi_result, hi_inv;

  assign addr_take = i_hsel & i_hready & i_htrans[1];

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      bus_reg       <= FPCC_BUS_IDLE;
      hreadyout_reg <= 1'b1;
      rd_addr_reg   <= '0;
    end else begin
      case (bus_reg)
        FPCC_BUS_IDLE: begin
          // A read costs one wait state so that the data reflect every earlier write.
          if (addr_take && !i_hwrite) begin
            bus_reg       <= FPCC_BUS_RD_WAIT;
            hreadyout_reg <= 1'b0;
            rd_addr_reg   <= i_haddr[ADDR_W-1:0];
          end
        end
        FPCC_BUS_RD_WAIT: begin
          bus_reg       <= FPCC_BUS_IDLE;
          hreadyout_reg <= 1'b1;
        end
        default: begin
          bus_reg       <= FPCC_BUS_IDLE;
          hreadyout_reg <= 1'b1;
        end
      endcase
    end
  end

  // Only whole-word writes are accepted; narrower ones complete but store nothing.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else begin
      wr_pend_reg <= addr_take & i_hwrite & (i_hsize == 3'h2);
      wr_addr_reg <= i_haddr[ADDR_W-1:0];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      hrdata_reg <= 32'h0;
    end else if (bus_reg == FPCC_BUS_RD_WAIT) begin
      case (rd_addr_reg)
        ADDR_W'(`FPCC_OFF_SRC_A_LO): hrdata_reg <= src_a_lo_reg;
        ADDR_W'(`FPCC_OFF_SRC_A_HI): hrdata_reg <= src_a_hi_reg;
        ADDR_W'(`FPCC_OFF_SRC_B_LO): hrdata_reg <= src_b_lo_reg;
        ADDR_W'(`FPCC_OFF_SRC_B_HI): hrdata_reg <= src_b_hi_reg;
        ADDR_W'(`FPCC_OFF_CTRL):     hrdata_reg <= {29'h0, ctrl_reg};
        ADDR_W'(`FPCC_OFF_CC):       hrdata_reg <= {24'h0, cc_reg};
        ADDR_W'(`FPCC_OFF_FLAGS):    hrdata_reg <= {27'h0, flags_reg};
        ADDR_W'(`FPCC_OFF_LAST):     hrdata_reg <= {22'h0, last_reg};
        ADDR_W'(`FPCC_OFF_COUNT):    hrdata_reg <= {16'h0, count_reg};
        default:                     hrdata_reg <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      src_a_lo_reg <= 32'h0;
      src_a_hi_reg <= 32'h0;
      src_b_lo_reg <= 32'h0;
      src_b_hi_reg <= 32'h0;
    end else if (wr_pend_reg) begin
      case (wr_addr_reg)
        ADDR_W'(`FPCC_OFF_SRC_A_LO): src_a_lo_reg <= i_hwdata;
        ADDR_W'(`FPCC_OFF_SRC_A_HI): src_a_hi_reg <= i_hwdata;
        ADDR_W'(`FPCC_OFF_SRC_B_LO): src_b_lo_reg <= i_hwdata;
        ADDR_W'(`FPCC_OFF_SRC_B_HI): src_b_hi_reg <= i_hwdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_reg <= `FPCC_CTRL_RST;
    end else if (wr_pend_reg && wr_addr_reg == ADDR_W'(`FPCC_OFF_CTRL)) begin
      ctrl_reg <= i_hwdata[2:0];
    end
  end

  // A write to the command register starts a compare and completes it in the same edge.
  assign go         = wr_pend_reg && (wr_addr_reg == ADDR_W'(`FPCC_OFF_CMD));
  assign cmd_cond   = i_hwdata[`FPCC_CMD_COND_LSB +: 4];
  assign cmd_sel    = i_hwdata[`FPCC_CMD_SEL_LSB +: 3];
  assign cmd_fmt    = fpcc_fmt_t'(i_hwdata[`FPCC_CMD_FMT_LSB +: 2]);
  assign is_ps      = (cmd_fmt == FPCC_FMT_PS);
  assign cmd_sel_hi = 3'(cmd_sel + 3'h1);

  fpcc_rel #(.EXP_W(`FPCC_DOUBLE_EXP), .MAN_W(`FPCC_DOUBLE_MAN)) u_rel_d (
    .i_a     ({src_a_hi_reg, src_a_lo_reg}),
    .i_b     ({src_b_hi_reg, src_b_lo_reg}),
    .o_less  (d_less),
    .o_equal (d_equal),
    .o_unord (d_unord),
    .o_signaling_nan  (d_signaling_nan),
    .o_quiet_nan  (d_quiet_nan)
  );

  fpcc_rel #(.EXP_W(`FPCC_SINGLE_EXP), .MAN_W(`FPCC_SINGLE_MAN)) u_rel_s (
    .i_a     (src_a_lo_reg),
    .i_b     (src_b_lo_reg),
    .o_less  (s_less),
    .o_equal (s_equal),
    .o_unord (s_unord),
    .o_signaling_nan  (s_signaling_nan),
    .o_quiet_nan  (s_quiet_nan)
  );

  // The upper single halves form the second lane of a paired compare.
  fpcc_rel #(.EXP_W(`FPCC_SINGLE_EXP), .MAN_W(`FPCC_SINGLE_MAN)) u_rel_h (
    .i_a     (src_a_hi_reg),
    .i_b     (src_b_hi_reg),
    .o_less  (h_less),
    .o_equal (h_equal),
    .o_unord (h_unord),
    .o_signaling_nan  (h_signaling_nan),
    .o_quiet_nan  (h_quiet_nan)
  );

  always_comb begin
    if (cmd_fmt == FPCC_FMT_D) begin
      lo_less  = d_less;
      lo_equal = d_equal;
      lo_unord = d_unord;
      lo_signaling_nan  = d_signaling_nan;
      lo_quiet_nan  = d_quiet_nan;
    end else begin
      lo_less  = s_less;
      lo_equal = s_equal;
      lo_unord = s_unord;
      lo_signaling_nan  = s_signaling_nan;
      lo_quiet_nan  = s_quiet_nan;
    end
  end

  fpcc_pred u_pred_lo (
    .i_less    (lo_less),
    .i_equal   (lo_equal),
    .i_unord   (lo_unord),
    .i_signaling_nan    (lo_signaling_nan),
    .i_quiet_nan    (lo_quiet_nan),
    .i_cond    (cmd_cond),
    .o_result  (lo_result),
    .o_invalid (lo_inv)
  );

  fpcc_pred u_pred_hi (
    .i_less    (h_less),
    .i_equal   (h_equal),
    .i_unord   (h_unord),
    .i_signaling_nan    (h_signaling_nan),
    .i_quiet_nan    (h_quiet_nan),
    .i_cond    (cmd_cond),
    .o_result  (hi_result),
    .o_invalid (hi_inv)
  );

  // Exceptions that stop the compare before it is evaluated, in priority order.
  assign copu_raise   = go & ~ctrl_reg[`FPCC_CTRL_COP_EN];
  assign resv_raise   = go & ~copu_raise & (cmd_fmt == FPCC_FMT_RSV);
  assign unimpl_raise = go & ~copu_raise & is_ps & ~ctrl_reg[`FPCC_CTRL_PS_EN];
  assign exec_ok      = go & ~copu_raise & ~resv_raise & ~unimpl_raise;
  assign inv_raise    = exec_ok & (lo_inv | (is_ps & hi_inv));
  assign inv_take     = inv_raise & ctrl_reg[`FPCC_CTRL_INV_EN];
  assign cc_write     = exec_ok & ~inv_take;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cc_reg <= `FPCC_CC_RST;
    end else if (cc_write) begin
      cc_reg[cmd_sel] <= lo_result;
      if (is_ps) begin
        cc_reg[cmd_sel_hi] <= hi_result;
      end
    end else if (wr_pend_reg && wr_addr_reg == ADDR_W'(`FPCC_OFF_CC)) begin
      cc_reg <= i_hwdata[7:0];
    end
  end

  // Sticky flags: a new event in the clearing cycle survives the clear.
  always_comb begin
    flags_next = flags_reg;
    if (wr_pend_reg && wr_addr_reg == ADDR_W'(`FPCC_OFF_FLAGS)) begin
      flags_next = flags_reg & ~i_hwdata[4:0];
    end
    flags_next[`FPCC_FLG_INV]     = flags_next[`FPCC_FLG_INV] | inv_raise;
    flags_next[`FPCC_FLG_INV_EXC] = flags_next[`FPCC_FLG_INV_EXC] | inv_take;
    flags_next[`FPCC_FLG_UNIMPL]  = flags_next[`FPCC_FLG_UNIMPL] | unimpl_raise;
    flags_next[`FPCC_FLG_COPU]    = flags_next[`FPCC_FLG_COPU] | copu_raise;
    flags_next[`FPCC_FLG_RESV]    = flags_next[`FPCC_FLG_RESV] | resv_raise;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      flags_reg <= `FPCC_FLAGS_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Exception pulses toward the pipeline, one cycle each.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      inv_exc_reg    <= 1'b0;
      unimpl_exc_reg <= 1'b0;
      copu_exc_reg   <= 1'b0;
      resv_exc_reg   <= 1'b0;
    end else begin
      inv_exc_reg    <= inv_take;
      unimpl_exc_reg <= unimpl_raise;
      copu_exc_reg   <= copu_raise;
      resv_exc_reg   <= resv_raise;
    end
  end

  // Relations and results of the last evaluated compare, and a count of them.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      last_reg  <= 10'h0;
      fmt_reg   <= FPCC_FMT_S;
      count_reg <= 16'h0;
    end else if (exec_ok) begin
      last_reg  <= {h_unord, h_equal, h_less, lo_unord, lo_equal, lo_less, hi_result, lo_result, inv_raise,
                    inv_take};
      fmt_reg   <= cmd_fmt;
      count_reg <= 16'(count_reg + 16'h1);
    end
  end

  assign o_hreadyout  = hreadyout_reg;
  assign o_hrdata     = hrdata_reg;
  assign o_hresp      = 1'b0;
  assign o_cond_codes = cc_reg;
  assign o_inv_exc    = inv_exc_reg;
  assign o_unimpl_exc = unimpl_exc_reg;
  assign o_copu_exc   = copu_exc_reg;
  assign o_resv_exc   = resv_exc_reg;
  assign o_last_fmt   = fmt_reg;

  nan_unord_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (go && (lo_signaling_nan || lo_quiet_nan)) |-> (lo_unord && !lo_less && !lo_equal))
    else $error("NaN operand did not force the unordered relation.");

  ordered_rel_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (go && !lo_unord) |-> !(lo_less && lo_equal))
    else $error("Ordered operands reported both less and equal.");

  cc_value_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    cc_write |=> (cc_reg[$past(cmd_sel)] ==
                  (($past(cmd_cond[2]) && $past(lo_less)) || ($past(cmd_cond[1]) && $past(lo_equal)) ||
                   ($past(cmd_cond[0]) && $past(lo_unord)))))
    else $error("Condition code differs from the predicate of the relations.");

  false_pred_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (cc_write && cmd_cond[2:0] == 3'h0) |=> !cc_reg[$past(cmd_sel)])
    else $error("Never-true predicate wrote a true result.");

  unord_pred_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (cc_write && cmd_cond[2:0] == 3'h1) |=> (cc_reg[$past(cmd_sel)] == $past(lo_unord)))
    else $error("Unordered-only predicate gave the wrong result.");

  eq_pred_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (cc_write && cmd_cond[2:1] == 2'h1) |=> (cc_reg[$past(cmd_sel)] ==
                                             ($past(lo_equal) || ($past(cmd_cond[0]) && $past(lo_unord)))))
    else $error("Equal based predicate gave the wrong result.");

  below_pred_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (cc_write && cmd_cond[2] && !lo_less && !lo_equal && !lo_unord) |=> !cc_reg[$past(cmd_sel)])
    else $error("Greater-than outcome produced true for a below predicate.");

  signaling_nan_inv_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (exec_ok && lo_signaling_nan) |=> flags_reg[`FPCC_FLG_INV])
    else $error("Signaling NaN did not set the invalid flag.");

  quiet_nan_sig_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (exec_ok && cmd_cond[3] && lo_quiet_nan && ctrl_reg[`FPCC_CTRL_INV_EN]) |=>
      o_inv_exc ##1 (o_inv_exc == $past(inv_take)))
    else $error("Signaling predicate with quiet NaN took no single exception.");

  quiet_nan_quiet_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (exec_ok && !cmd_cond[3] && !lo_signaling_nan && !(is_ps && h_signaling_nan)) |=> !o_inv_exc)
    else $error("Quiet predicate raised invalid without a signaling NaN.");

  ps_upper_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (cc_write && is_ps && !cmd_sel[0]) |=> (cc_reg[$past(cmd_sel_hi)] == $past(hi_result)))
    else $error("Upper half result missing from the next condition code.");

  ps_or_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (exec_ok && is_ps && hi_inv && !lo_inv) |=> flags_reg[`FPCC_FLG_INV])
    else $error("Upper half invalid operation was not reported.");

  exc_nowrite_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    inv_take |=> ($stable(cc_reg) && o_inv_exc))
    else $error("Taken invalid exception still wrote a condition code.");

  zero_sign_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (go && cmd_fmt == FPCC_FMT_S && ((src_a_lo_reg == 32'h80000000 && src_b_lo_reg == 32'h0) ||
                                     (src_a_lo_reg == 32'h0 && src_b_lo_reg == 32'h80000000)))
      |-> (lo_equal && !lo_less))
    else $error("Signed zeros did not compare equal.");

  copu_block_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    copu_raise |=> (o_copu_exc && $stable(cc_reg) && flags_reg[`FPCC_FLG_COPU]))
    else $error("Coprocessor-unusable compare was not refused.");
endmodule

// *** verification/fpcc_issuer.sv ***
// Bus master standing in for the instruction issue side that sends compare commands.
`timescale 1ns/1ps
module fpcc_issuer (
  input  wire logic        i_core_clk,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hrdata,
  output logic [31:0]      o_haddr,
  output logic [1:0]       o_htrans,
  output logic             o_hwrite,
  output logic [2:0]       o_hsize,
  output logic [31:0]      o_hwdata
);
  initial begin
    o_haddr  = 32'h0;
    o_htrans = 2'h0;
    o_hwrite = 1'b0;
    o_hsize  = 3'h2;
    o_hwdata = 32'h0;
  end

  // Each phase is held until ready is seen high at a rising edge; read data is taken at the second one.
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
    @(posedge i_core_clk);
    o_htrans <= 2'h2;
    o_haddr  <= {24'h0, addr};
    o_hwrite <= wr;
    do @(posedge i_core_clk); while (i_hready !== 1'b1);
    o_htrans <= 2'h0;
    o_hwdata <= wr ? wdata : ~o_hwdata;
    do @(posedge i_core_clk); while (i_hready !== 1'b1);
    rdata = i_hrdata;
  endtask
endmodule

// *** verification/fp_compare_condition_unit_tb_top.sv ***
// Self-checking bench for the compare unit, driven through its register bus.
`timescale 1ns/1ps
`include "fpcc_map.svh"
module fp_compare_condition_unit_tb_top;
  import fpcc_pkg::*;
  logic               i_core_clk = 1'b0;
  logic               i_rst      = 1'b1;
  logic [31:0]        haddr, hwdata, hrdata, rd;
  logic [1:0]         htrans;
  logic [2:0]         hsize, sel;
  logic               hwrite, hready, inv_exc, res;
  logic               hresp, unimpl_exc, copu_exc, resv_exc;
  logic [7:0]         cond_codes, exp_cc;
  logic [3:0]         cd;
  fpcc_fmt_t          last_fmt;
  int                 miscompares = 0;
  int                 compares    = 0;
  int                 cycles      = 0;
  int                 inv_pulses  = 0;
  int                 ref_pulses [3] = '{0, 0, 0};
  int                 n;
  logic [31:0]        a_tab [5]   = '{32'h3f800000, 32'h40000000, 32'h00000000, 32'h7fc00000, 32'h7f800001};
  logic [31:0]        b_tab [5]   = '{32'h40000000, 32'h3f800000, 32'h80000000, 32'h3f800000, 32'h3f800000};
  logic [2:0]         rel_tab [5] = '{3'b001, 3'b000, 3'b010, 3'b100, 3'b100};
  logic               sn_tab [5]  = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic [2:0]         ctl_tab [3] = '{3'b110, 3'b010, 3'b100};
  logic [1:0]         fmt_tab [3] = '{2'h3, 2'h2, 2'h0};
  logic [31:0]        flg_tab [3] = '{32'h10, 32'h04, 32'h08};

  always #10 i_core_clk = ~i_core_clk;

  fpcc_issuer issuer (.i_core_clk(i_core_clk), .i_hready(hready), .i_hrdata(hrdata), .o_haddr(haddr),
    .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata));

  fpcc_top DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
    .o_hrdata(hrdata), .o_hresp(hresp), .o_cond_codes(cond_codes), .o_inv_exc(inv_exc),
    .o_unimpl_exc(unimpl_exc), .o_copu_exc(copu_exc), .o_resv_exc(resv_exc), .o_last_fmt(last_fmt));

  task automatic wrap_up();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    issuer.xfer(1'b1, addr, data, rd);
  endtask

  task automatic rdc(input logic [7:0] addr, input logic [31:0] exp, input string name);
    issuer.xfer(1'b0, addr, 32'h0, rd);
    check(name, rd, exp);
  endtask

  always @(posedge i_core_clk) begin
    cycles++;
    if (inv_exc === 1'b1) begin
      inv_pulses++;
    end
    ref_pulses[0] += (resv_exc === 1'b1) ? 1 : 0;
    ref_pulses[1] += (unimpl_exc === 1'b1) ? 1 : 0;
    ref_pulses[2] += (copu_exc === 1'b1) ? 1 : 0;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    exp_cc = 8'h00;
    repeat (5) @(posedge i_core_clk);
    i_rst <= 1'b0;
    rdc(`FPCC_OFF_CC, 32'h0, "cond_codes_reset");
    rdc(8'h30, 32'h0, "unmapped");
    for (int p = 0; p < 5; p++) begin
      wr(`FPCC_OFF_SRC_A_LO, a_tab[p]);
      wr(`FPCC_OFF_SRC_B_LO, b_tab[p]);
      for (int c = 0; c < 16; c++) begin
        cd = c[3:0];
        sel = c[2:0] + p[2:0];
        res = (cd[2] & rel_tab[p][0]) | (cd[1] & rel_tab[p][1]) | (cd[0] & rel_tab[p][2]);
        exp_cc[sel] = res;
        wr(`FPCC_OFF_CMD, {22'h0, 2'h0, 1'b0, sel, cd});
        rdc(`FPCC_OFF_CC, {24'h0, exp_cc}, "cond_codes");
        check("cond_codes_pins", {24'h0, cond_codes}, {24'h0, exp_cc});
        rdc(`FPCC_OFF_FLAGS, {31'h0, sn_tab[p] | (cd[3] & rel_tab[p][2])}, "flags");
        wr(`FPCC_OFF_FLAGS, 32'h1f);
      end
    end
    $display("predicate table test done");
    wr(`FPCC_OFF_CTRL, 32'h7);
    for (int q = 0; q < 2; q++) begin
      wr(`FPCC_OFF_SRC_A_LO, (q == 0) ? 32'h7f800001 : 32'h7fc00000);
      n = inv_pulses;
      wr(`FPCC_OFF_CMD, {22'h0, 2'h0, 1'b0, 3'h3, (q == 0) ? 4'h2 : 4'hc});
      rdc(`FPCC_OFF_CC, {24'h0, exp_cc}, "cond_codes_exc");
      rdc(`FPCC_OFF_FLAGS, 32'h3, "flags_exc");
      check("inv_pulses", 32'(inv_pulses), 32'(n + 1));
      wr(`FPCC_OFF_FLAGS, 32'h1f);
    end
    $display("invalid exception test done");
    wr(`FPCC_OFF_SRC_A_LO, 32'h40000000);
    wr(`FPCC_OFF_SRC_B_LO, 32'h40000000);
    wr(`FPCC_OFF_SRC_A_HI, 32'h3f800000);
    wr(`FPCC_OFF_SRC_B_HI, 32'h40000000);
    wr(`FPCC_OFF_CMD, {22'h0, 2'h2, 1'b0, 3'h4, 4'h4});
    exp_cc[4] = 1'b0;
    exp_cc[5] = 1'b1;
    rdc(`FPCC_OFF_CC, {24'h0, exp_cc}, "cond_codes_paired");
    rdc(`FPCC_OFF_FLAGS, 32'h0, "flags_paired");
    wr(`FPCC_OFF_SRC_A_HI, 32'h7f800001);
    wr(`FPCC_OFF_CMD, {22'h0, 2'h2, 1'b0, 3'h6, 4'h2});
    rdc(`FPCC_OFF_CC, {24'h0, exp_cc}, "cond_codes_paired_exc");
    rdc(`FPCC_OFF_FLAGS, 32'h3, "flags_paired_exc");
    wr(`FPCC_OFF_FLAGS, 32'h1f);
    $display("paired single test done");
    wr(`FPCC_OFF_SRC_A_HI, 32'h3ff00000);
    wr(`FPCC_OFF_SRC_A_LO, 32'h0);
    wr(`FPCC_OFF_SRC_B_HI, 32'h40000000);
    wr(`FPCC_OFF_SRC_B_LO, 32'h0);
    wr(`FPCC_OFF_CC, 32'h0);
    exp_cc = 8'h02;
    wr(`FPCC_OFF_CMD, {22'h0, 2'h1, 1'b0, 3'h1, 4'h4});
    rdc(`FPCC_OFF_CC, {24'h0, exp_cc}, "cond_codes_double");
    check("last_fmt", {30'h0, last_fmt}, {30'h0, FPCC_FMT_D});
    $display("double test done");
    for (int k = 0; k < 3; k++) begin
      wr(`FPCC_OFF_CTRL, {29'h0, ctl_tab[k]});
      n = ref_pulses[k];
      wr(`FPCC_OFF_CMD, {22'h0, fmt_tab[k], 1'b0, 3'h0, 4'h7});
      check("hresp_refused", {31'h0, hresp}, 32'h0);
      rdc(`FPCC_OFF_CC, {24'h0, exp_cc}, "cond_codes_refused");
      rdc(`FPCC_OFF_FLAGS, flg_tab[k], "flags_refused");
      check("refused_pulse", 32'(ref_pulses[k]), 32'(n + 1));
      wr(`FPCC_OFF_FLAGS, 32'h1f);
    end
    $display("refusal test done");
    wrap_up();
  end
endmodule
